// ---- rtl/swrc_pkg.sv ----
// Shared constants and types for suspend, wakeup and reset control
package swrc_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned RST_HOLD_MS    = 5;
  localparam int unsigned RST_HOLD_CYC   =
    RST_HOLD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W      = 20;
  localparam logic [15:0] PID_DEFAULT    = 16'h1111;
  localparam logic [15:0] PID_ALTERNATE  = 16'h2222;
  localparam logic        CLK_SEL_48M    = 1'b1;
  localparam logic        CLK_SEL_6M     = 1'b0;

  typedef enum logic [2:0] {
    SWRC_ST_HOLD  = 3'b001,
    SWRC_ST_RUN   = 3'b010,
    SWRC_ST_XRST  = 3'b100
  } swrc_rst_state_t;
endpackage : swrc_pkg

// ---- rtl/swrc_strobe_if.sv ----
// Strobe path between input conditioning and the control core
`timescale 1ns/100ps
interface swrc_strobe_if;
  logic strobe;
  modport src (output strobe);
  modport dst (input strobe);
endinterface : swrc_strobe_if

// ---- rtl/swrc_strobe_det.sv ----
// Synchroniser and falling-edge detector for the strobe input
`timescale 1ns/100ps
module swrc_strobe_det (
  input  wire logic   clk_sys,
  input  wire logic   reset_n,
  input  wire logic   pin_n,
  swrc_strobe_if.src  out
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pin_n;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign out.strobe = last_q & ~sync_q;
endmodule : swrc_strobe_det

// ---- rtl/swrc_ctrl.sv ----
// Suspend, wakeup, reset-out and strap control core
`timescale 1ns/100ps
module swrc_ctrl
  import swrc_pkg::*;
#(
  parameter int unsigned HOLD_CYC = swrc_pkg::RST_HOLD_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        usb_configured,
  input  wire logic        usb_suspended,
  input  wire logic        usb_bus_reset,
  input  wire logic        remote_wake_en,
  input  wire logic        if_pulldown_en,
  input  wire logic        test_mode,
  input  wire logic        send_now_wake_n,
  input  wire logic        osc_in,
  input  wire logic        cfgmem_select_i,
  input  wire logic        cfgmem_clock_i,
  input  wire logic        cfgmem_select_o,
  input  wire logic        cfgmem_clock_o,
  input  wire logic        cfgmem_data_o,
  input  wire logic        cfgmem_data_oe,
  input  wire logic        tx_space_n_core,
  input  wire logic        rx_avail_n_core,
  output logic             power_enable_n,
  output logic             resume_req,
  output logic             tx_flush_req,
  output logic             reset_out_n_o,
  output logic             reset_out_n_oe,
  output logic             core_reset,
  output logic             clk_sel_48m,
  output logic             pid_alternate,
  output logic [15:0]      product_id,
  output logic             osc_out,
  output logic             cfgmem_select_oe,
  output logic             cfgmem_select_out,
  output logic             cfgmem_clock_oe,
  output logic             cfgmem_clock_out,
  output logic             cfgmem_data_oe_pin,
  output logic             cfgmem_data_out,
  output logic             cfgmem_pullup_en,
  output logic             tx_space_n_o,
  output logic             tx_space_n_oe,
  output logic             rx_avail_n_o,
  output logic             rx_avail_n_oe,
  output logic             status_pullup_en,
  output logic             fifo_in_pullup_en,
  output logic             fifo_in_pulldown_en,
  output logic             test_active
);
  import swrc_pkg::*;

  swrc_strobe_if   strobe_if ();
  swrc_rst_state_t state_q;
  swrc_rst_state_t state_d;
  logic [RST_CNT_W-1:0] cnt_q;
  logic            in_reset;
  logic            pwr_q;
  logic            strap_last;
  logic            sel48_q;
  logic            pidalt_q;
  logic            resume_q;
  logic            flush_q;
  logic            osc_q;

  swrc_strobe_det u_strobe (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pin_n   (send_now_wake_n),
    .out     (strobe_if.src)
  );

  // core_reset holds the core in reset during start-up or external reset
  assign in_reset   = (state_q != SWRC_ST_RUN);
  assign core_reset = in_reset;

  // start-up delay then run; external reset
  always_comb begin
    state_d = state_q;
    case (state_q)
      SWRC_ST_HOLD:
        if (cnt_q >= RST_CNT_W'(HOLD_CYC - 1)) begin
          state_d = SWRC_ST_RUN;
        end
      SWRC_ST_RUN:
        state_d = SWRC_ST_RUN;
      SWRC_ST_XRST:
        state_d = SWRC_ST_HOLD;
      default:
        state_d = SWRC_ST_HOLD;
    endcase
  end

  // bus reset deliberately not an input to this sequence
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= SWRC_ST_XRST;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == SWRC_ST_HOLD) begin
        cnt_q <= cnt_q + RST_CNT_W'(1);
      end else begin
        cnt_q <= '0;
      end
    end
  end

  // float while holding, driven high when running
  always_comb begin
    reset_out_n_o  = 1'b0;
    reset_out_n_oe = 1'b0;
    case (state_q)
      SWRC_ST_XRST: begin
        reset_out_n_oe = 1'b1;
      end
      SWRC_ST_RUN: begin
        reset_out_n_o  = 1'b1;
        reset_out_n_oe = 1'b1;
      end
      default: begin
        reset_out_n_oe = 1'b0;
      end
    endcase
  end

  // power enable follows configuration and suspend
  always_ff @(posedge clk_sys) begin
    if (!reset_n || in_reset) begin
      pwr_q <= 1'b1;
    end else begin
      pwr_q <= !(usb_configured && !usb_suspended);
    end
  end
  assign power_enable_n = pwr_q;

  always_ff @(posedge clk_sys) begin
    if (!reset_n || in_reset) begin
      resume_q <= 1'b0;
      flush_q  <= 1'b0;
    end else begin
      resume_q <= strobe_if.strobe && pwr_q && remote_wake_en;
      flush_q  <= strobe_if.strobe && !pwr_q;
    end
  end
  assign resume_req   = resume_q;
  assign tx_flush_req = flush_q;

  // Last hold cycle: pins still released, so only the resistors set them
  assign strap_last = (state_q == SWRC_ST_HOLD) && (state_d == SWRC_ST_RUN);

  // straps caught on the last reset cycle
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sel48_q  <= CLK_SEL_6M;
      pidalt_q <= 1'b0;
    end else if (strap_last) begin
      sel48_q  <= cfgmem_select_i ? CLK_SEL_6M : CLK_SEL_48M;
      pidalt_q <= !cfgmem_clock_i;
    end
  end
  assign clk_sel_48m   = sel48_q;
  assign pid_alternate = pidalt_q;
  assign product_id    = pidalt_q ? PID_ALTERNATE : PID_DEFAULT;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      osc_q <= 1'b0;
    end else if (!usb_suspended) begin
      osc_q <= osc_in;
    end
  end
  assign osc_out = osc_q;

  // config memory pins released with pull-up in reset
  assign cfgmem_pullup_en   = in_reset;
  assign cfgmem_select_oe   = !in_reset;
  assign cfgmem_select_out  = cfgmem_select_o;
  assign cfgmem_clock_oe    = !in_reset;
  assign cfgmem_clock_out   = cfgmem_clock_o;
  assign cfgmem_data_oe_pin = !in_reset && cfgmem_data_oe;
  assign cfgmem_data_out    = cfgmem_data_o;

  // status outputs released with pull-up in reset
  assign status_pullup_en = in_reset;
  assign tx_space_n_oe    = !in_reset;
  assign rx_avail_n_oe    = !in_reset;
  assign tx_space_n_o     = tx_space_n_core;
  assign rx_avail_n_o     = rx_avail_n_core;

  // pull-down replaces pull-up while power is off (suspended or unconfigured) out of reset, when enabled
  assign fifo_in_pulldown_en = if_pulldown_en && pwr_q && !in_reset;
  assign fifo_in_pullup_en   = !fifo_in_pulldown_en;

  // test mode is only reported; board must hold it low
  assign test_active = test_mode;
endmodule : swrc_ctrl

// ---- tb/swrc_assertions.sv ----
// Port checks for the suspend, wakeup and reset core
`timescale 1ns/100ps
module swrc_assertions (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic usb_configured,
  input wire logic usb_suspended,
  input wire logic remote_wake_en,
  input wire logic send_now_wake_n,
  input wire logic power_enable_n,
  input wire logic resume_req,
  input wire logic tx_flush_req,
  input wire logic reset_out_n_o,
  input wire logic reset_out_n_oe,
  input wire logic core_reset,
  input wire logic osc_out,
  input wire logic cfgmem_select_oe,
  input wire logic cfgmem_clock_oe,
  input wire logic cfgmem_pullup_en,
  input wire logic tx_space_n_oe,
  input wire logic status_pullup_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  pwr_on_a: assert property (!core_reset && usb_configured &&
    !usb_suspended |=> !power_enable_n) else $error("pwr stuck high");
  pwr_off_a: assert property (usb_suspended |=> power_enable_n)
    else $error("pwr low in suspend");
  rst_drive_a: assert property (disable iff (1'b0) !reset_n |=>
    reset_out_n_oe && !reset_out_n_o) else $error("reset_out_n not low");
  rst_float_a: assert property ($rose(reset_n) |-> ##2
    !reset_out_n_oe [*8]) else $error("reset_out_n not floating");
  flush_resp_a: assert property ($fell(send_now_wake_n) &&
    !power_enable_n && !core_reset |-> ##[3:5] tx_flush_req)
    else $error("no flush");
  resume_cond_a: assert property (resume_req |->
    power_enable_n && remote_wake_en) else $error("bad resume");
  pulse_once_a: assert property (tx_flush_req || resume_req |=>
    !tx_flush_req && !resume_req) else $error("long pulse");
  osc_hold_a: assert property (usb_suspended && $past(usb_suspended)
    && !core_reset |-> $stable(osc_out)) else $error("osc runs");
  pins_float_a: assert property (core_reset |-> !cfgmem_select_oe &&
    !cfgmem_clock_oe && !tx_space_n_oe && cfgmem_pullup_en &&
    status_pullup_en) else $error("pins driven in reset");
endmodule : swrc_assertions

// ---- tb/swrc_board.sv ----
// Board model: strap resistors and oscillator source
`timescale 1ns/100ps
module swrc_board (
  input  wire logic clk_sys,
  input  wire logic sel_pd,
  input  wire logic clk_pd,
  input  wire logic cfgmem_select_oe,
  input  wire logic cfgmem_select_out,
  input  wire logic cfgmem_clock_oe,
  input  wire logic cfgmem_clock_out,
  output logic      cfgmem_select_i,
  output logic      cfgmem_clock_i,
  output logic      osc_in
);
  logic [2:0] div_q = 3'h0;
  // released pins
  // A 10K pull-down outweighs the weak internal pull-up
  assign cfgmem_select_i = cfgmem_select_oe ? cfgmem_select_out : !sel_pd;
  assign cfgmem_clock_i = cfgmem_clock_oe ? cfgmem_clock_out : !clk_pd;
  always @(posedge clk_sys) div_q <= div_q + 3'h1;
  assign osc_in = div_q[2];
endmodule : swrc_board

// ---- tb/test_suspend_wakeup_reset_control.sv ----
// Bench for the suspend, wakeup and reset core
`timescale 1ns/100ps
module test_suspend_wakeup_reset_control;
  import swrc_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, usb_configured = 1'b0;
  logic usb_suspended = 1'b0, usb_bus_reset = 1'b0, remote_wake_en = 1'b1;
  logic if_pulldown_en = 1'b0, send_now_wake_n = 1'b1, sel_pd = 1'b1;
  logic clk_pd = 1'b0, tx_space_n_core = 1'b1, rx_avail_n_core = 1'b1;
  logic test_mode = 1'b0, cfgmem_select_o = 1'b0, cfgmem_clock_o = 1'b0;
  logic cfgmem_data_o = 1'b0, cfgmem_data_oe = 1'b0;
  logic osc_in, cfgmem_select_i, cfgmem_clock_i, power_enable_n;
  logic resume_req, tx_flush_req, reset_out_n_o, reset_out_n_oe;
  logic core_reset, osc_out, clk_sel_48m, pid_alternate, cfgmem_select_oe;
  logic cfgmem_select_out, cfgmem_clock_oe, cfgmem_clock_out;
  logic cfgmem_data_oe_pin, cfgmem_data_out, cfgmem_pullup_en;
  logic tx_space_n_o, tx_space_n_oe, rx_avail_n_o, rx_avail_n_oe;
  logic status_pullup_en, fifo_in_pullup_en, fifo_in_pulldown_en;
  logic test_active;
  logic [15:0] product_id;
  int mismatches = 0;
  int check_count = 0;
  swrc_ctrl #(.HOLD_CYC(20)) DUT (.*);
  swrc_board u_board (.*);
  always #5 clk_sys = ~clk_sys;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic do_reset(logic sp, logic cp, logic es, logic [15:0] ep);
    int i;
    @(posedge clk_sys);
    sel_pd <= sp;
    clk_pd <= cp;
    reset_n <= 1'b0;
    tick(6);
    chk("rst_oe", 1, reset_out_n_oe);
    chk("rst_o", 0, reset_out_n_o);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    tick(3);
    chk("rst_float", 0, reset_out_n_oe);
    chk("sel_oe", 0, cfgmem_select_oe);
    chk("txe_oe", 0, tx_space_n_oe);
    chk("rxf_oe", 0, rx_avail_n_oe);
    chk("st_pullup", 1, status_pullup_en);
    chk("sk_oe", 0, cfgmem_clock_oe);
    chk("dat_oe", 0, cfgmem_data_oe_pin);
    chk("cfg_pullup", 1, cfgmem_pullup_en);
    for (i = 0; i < 40 && core_reset !== 1'b0; i++)
      tick(1);
    tick(3);
    chk("rst_high", 1, reset_out_n_o & reset_out_n_oe);
    chk("clk_sel", es, clk_sel_48m);
    chk("pid", ep, product_id);
    chk("pid_alt", ep == PID_ALTERNATE, pid_alternate);
    chk("sk_oe_run", 1, cfgmem_clock_oe);
    chk("cfg_pullup_run", 0, cfgmem_pullup_en);
    chk("txe_oe_run", 1, tx_space_n_oe);
    chk("st_pullup_run", 0, status_pullup_en);
  endtask : do_reset
  task automatic strobe(logic ef, logic er);
    int nf = 0;
    int nr = 0;
    @(posedge clk_sys);
    send_now_wake_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    send_now_wake_n <= 1'b1;
    repeat (10) begin
      #1;
      nf += tx_flush_req;
      nr += resume_req;
      @(posedge clk_sys);
    end
    chk("flush", ef, nf[15:0]);
    chk("resume", er, nr[15:0]);
  endtask : strobe
  task automatic t_normal;
    @(posedge clk_sys);
    usb_configured <= 1'b1;
    tx_space_n_core <= 1'b0;
    rx_avail_n_core <= 1'b0;
    tick(2);
    chk("pwr", 0, power_enable_n);
    chk("txe_pin", 0, tx_space_n_o);
    chk("rxf_pin", 0, rx_avail_n_o);
    chk("pull_up", 1, fifo_in_pullup_en);
    chk("test", 0, test_active);
    strobe(1'b1, 1'b0);
    @(posedge clk_sys);
    usb_bus_reset <= 1'b1;
    tick(3);
    chk("rst_bus", 1, reset_out_n_o & reset_out_n_oe);
  endtask : t_normal
  task automatic t_suspend;
    logic osc_seen;
    @(posedge clk_sys);
    usb_suspended <= 1'b1;
    if_pulldown_en <= 1'b1;
    tick(2);
    chk("pwr", 1, power_enable_n);
    chk("pull_dn", 1, fifo_in_pulldown_en);
    chk("pull_up_off", 0, fifo_in_pullup_en);
    osc_seen = osc_out;
    tick(9);
    chk("osc_frozen", osc_seen, osc_out);
    strobe(1'b0, 1'b1);
    @(posedge clk_sys);
    remote_wake_en <= 1'b0;
    strobe(1'b0, 1'b0);
  endtask : t_suspend
  initial begin
    do_reset(1'b1, 1'b0, CLK_SEL_48M, PID_DEFAULT);
    t_normal();
    t_suspend();
    do_reset(1'b0, 1'b1, CLK_SEL_6M, PID_ALTERNATE);
    end_sim();
  end
  // Whole run is under two hundred cycles
  initial begin
    #50000;
    mismatches++;
    end_sim();
  end
endmodule : test_suspend_wakeup_reset_control
bind swrc_ctrl swrc_assertions u_chk (.*);
